// file: design/cdt_timing.sv
// Dump timing, switching, noise schedule, display and bank control
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Five rate and duty pairs only
// - At 1 Hz unequal, 0.9/0.1 s split
// - Calibration every other or every tenth dump
// - Noise drive on in signal phases only
// - Each phase starts blanked, registers cleared
// - Blanking 4 to 26 ms, 2 ms steps
// - Integrate only after blanking ends
// - Data lamp on at dump, off when read
// - Integration lamp on during signal half
// - Display lamp on for signal channel
// - Dump lamp off at start, on halfway
// - Lamp test forces all lamps on
// - Hold mode: fixed channel, refresh each dump
// - Step mode: 0.8 to 3.5 Hz, data follows
// - Fast modes 10/50/250 ch/s, data off
// - Non-hold modes need advance toggle
// - Test output is clock divided by two
// - Interrupt at each dump end
// - Two banks; previous stable one dump
// - Transferred word top bit alternates
// - Dump period one or ten seconds
// - Settings sampled in last half cycle
module cdt_timing #(
  parameter int MS_CYCLES = cdt_pkg::MS_CYCLES // Cycles per millisecond
)
(
  // Clock, reset and freeze
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Correlator side
  input wire logic corrWe,
  input wire logic [2:0] corrAddr,
  input wire logic [cdt_pkg::WORD_W-1:0] corrData,
  output logic integrate,
  output logic clearRegs,
  output logic sigPhase,
  output logic bankSel,
  output logic dumpIrq,
  // Panel
  output logic updateIndicator,
  output logic dataAvailableIndicator,
  output logic intPhaseLamp,
  output logic dispPhaseLamp,
  output logic noiseSourceIndicator,
  output logic dumpTimeIndicator,
  output logic noiseDrive,
  output logic dataDispOn,
  output logic testOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Controls and tick
  // ----------------------------------------
  logic [31:0] ctrl; // Control register
  logic [31:0] ctrlSnap; // Settings sent with the dump
  logic [2:0] rate; // Rate and duty select
  logic [3:0] blankSel; // Blanking step count
  logic dumpLong; // Ten second dump
  logic calTenth; // Calibrate every tenth dump
  logic lampTest; // Force lamps on
  logic testSignalSelect; // Test output select
  logic [2:0] displayModeSelect; // Display mode
  logic advanceToggle; // Advance toggle up or down
  logic [3:0] rateKnob; // Step rate knob
  logic tick; // Millisecond pulse
  assign rate = ctrl[cdt_pkg::F_RATE +: 3];
  assign blankSel = ctrl[cdt_pkg::F_BLANK +: 4];
  assign dumpLong = ctrl[cdt_pkg::F_DUMP];
  assign calTenth = ctrl[cdt_pkg::F_CAL];
  assign lampTest = ctrl[cdt_pkg::F_LTEST];
  assign testSignalSelect = ctrl[cdt_pkg::F_TEST];
  assign displayModeSelect = ctrl[cdt_pkg::F_MODE +: 3];
  assign advanceToggle = ctrl[cdt_pkg::F_ADV];
  assign rateKnob = ctrl[cdt_pkg::F_KNOB +: 4];
  cdt_tick_if msIf();
  cdt_ms_tick #(.CYC(MS_CYCLES)) uTick (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .t(msIf)
  );
  assign tick = msIf.tick;
  // ----------------------------------------
  // Dump period
  // ----------------------------------------
  logic [13:0] dumpMs; // Milliseconds into the dump
  logic [13:0] dumpLen; // Dump length
  logic dumpEnd; // Last millisecond of the dump ends now
  logic [3:0] dumpIdx; // Dump count in the calibration schedule
  logic calOn; // Calibration dump
  assign dumpLen = dumpLong ? cdt_pkg::DUMP_LONG_MS : cdt_pkg::DUMP_SHORT_MS;
  assign dumpEnd = tick && (dumpMs >= dumpLen - 14'h0001);
  assign calOn = (dumpIdx == 4'h0);
  // Dump counter and calibration schedule
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dumpMs <= 14'h0000;
      dumpIdx <= 4'h0;
    end
    else if (ce && tick)
    begin
      dumpMs <= dumpEnd ? 14'h0000 : dumpMs + 14'h0001;
      if (dumpEnd)
        dumpIdx <= (dumpIdx >= (calTenth ? cdt_pkg::CAL_LAST_TENTH : cdt_pkg::CAL_LAST_OTHER))
          ? 4'h0 : dumpIdx + 4'h1;
    end
  end
  // ----------------------------------------
  // Switching phases
  // ----------------------------------------
  cdt_pkg::cdt_phase_e phase; // Current phase
  cdt_pkg::cdt_phase_e next_phase; // Phase after this cycle
  logic [9:0] phaseMs; // Milliseconds into the phase
  logic [9:0] phaseLen; // Length of this half
  logic [9:0] blankLen; // Blanking length
  logic [9:0] halfCyc; // Half the switching cycle
  logic sigNow; // Phase is signal
  logic phaseEnd; // Phase ends on this tick
  logic blankDone; // Blanking ends on this tick
  assign sigNow = (phase == cdt_pkg::PH_BSIG) || (phase == cdt_pkg::PH_ISIG);
  assign phaseLen = cdt_pkg::halfMs(rate, !sigNow);
  assign blankLen = cdt_pkg::blankMs(blankSel);
  assign halfCyc = 10'((cdt_pkg::halfMs(rate, 1'b0) + cdt_pkg::halfMs(rate, 1'b1)) >> 1);
  assign phaseEnd = tick && (phaseMs >= phaseLen - 10'h001);
  assign blankDone = tick && (phaseMs + 10'h001 >= blankLen);
  // Next phase: blank, integrate, swap halves
  always_comb
  begin
    next_phase = phase;
    case (phase)
      cdt_pkg::PH_BSIG: if (blankDone) next_phase = cdt_pkg::PH_ISIG;
      cdt_pkg::PH_ISIG: if (phaseEnd) next_phase = cdt_pkg::PH_BREF;
      cdt_pkg::PH_BREF: if (blankDone) next_phase = cdt_pkg::PH_IREF;
      cdt_pkg::PH_IREF: if (phaseEnd) next_phase = cdt_pkg::PH_BSIG;
      default: next_phase = cdt_pkg::PH_BSIG;
    endcase
    if (dumpEnd)
      next_phase = cdt_pkg::PH_BSIG;
  end
  // Phase state and its millisecond count
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase <= cdt_pkg::PH_BSIG;
      phaseMs <= 10'h000;
    end
    else if (ce)
    begin
      phase <= next_phase;
      if (dumpEnd || phaseEnd)
        phaseMs <= 10'h000;
      else if (tick)
        phaseMs <= phaseMs + 10'h001;
    end
  end
  // Correlator strobes and noise drive
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      integrate <= 1'b0;
      clearRegs <= 1'b0;
      sigPhase <= 1'b1;
      noiseDrive <= 1'b0;
    end
    else if (ce)
    begin
      integrate <= (next_phase == cdt_pkg::PH_ISIG) || (next_phase == cdt_pkg::PH_IREF);
      clearRegs <= dumpEnd || phaseEnd;
      sigPhase <= (next_phase == cdt_pkg::PH_BSIG) || (next_phase == cdt_pkg::PH_ISIG);
      // Dump end drops the drive so an old schedule never leaks into the next dump
      noiseDrive <= calOn && !dumpEnd &&
        ((next_phase == cdt_pkg::PH_BSIG) || (next_phase == cdt_pkg::PH_ISIG));
    end
  end
  // Settings snapshot at the start of the final half cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrlSnap <= cdt_pkg::CTRL_RESET;
    else if (ce && tick && (dumpMs == dumpLen - {4'h0, halfCyc}))
      ctrlSnap <= ctrl;
  end
  // ----------------------------------------
  // Banks and dump hand-over
  // ----------------------------------------
  logic [cdt_pkg::WORD_W-1:0] mem [0:2*cdt_pkg::MEM_DEPTH-1]; // Two banks
  logic dataAvail; // Previous bank waits for the computer
  logic [2:0] rdPtr; // Next word to hand over
  logic apbDone; // Access completes at this edge
  logic dataPop; // Computer takes a dump word
  logic lastPop; // Final word of the bank taken
  assign dataPop = apbDone && !pwrite && (paddr == cdt_pkg::REG_DATA);
  assign lastPop = dataPop && (rdPtr == 3'(cdt_pkg::MEM_DEPTH - 1));
  // Correlator writes into the bank being filled
  always_ff @(posedge clk_sys)
  begin
    if (ce && corrWe)
      mem[{bankSel, corrAddr}] <= corrData;
  end
  // Bank swap, availability flag and interrupt
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bankSel <= 1'b0;
      dataAvail <= 1'b0;
      dumpIrq <= 1'b0;
      rdPtr <= 3'h0;
    end
    else if (ce)
    begin
      dumpIrq <= dumpEnd;
      if (dumpEnd)
      begin
        bankSel <= !bankSel;
        dataAvail <= 1'b1;
        rdPtr <= 3'h0;
      end
      else
      begin
        if (lastPop)
          dataAvail <= 1'b0;
        if (dataPop)
          rdPtr <= rdPtr + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // Display
  // ----------------------------------------
  logic [7:0] chan; // Shown channel number
  logic [10:0] advCnt; // Milliseconds since last step
  logic [cdt_pkg::WORD_W-1:0] dispData; // Shown channel data
  logic dispRefresh; // Reload shown data next cycle
  logic isHold; // Hold-channel mode
  logic advActive; // Stepping enabled
  assign isHold = (displayModeSelect == cdt_pkg::M_HOLD);
  assign advActive = !isHold && advanceToggle;
  // Channel stepping
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      chan <= 8'h00;
      advCnt <= 11'h000;
      dispRefresh <= 1'b0;
    end
    else if (ce)
    begin
      dispRefresh <= isHold ? dumpEnd : 1'b0;
      if (advActive && tick)
      begin
        if (advCnt >= cdt_pkg::advMs(displayModeSelect, rateKnob) - 11'h001)
        begin
          advCnt <= 11'h000;
          chan <= (chan >= cdt_pkg::CHAN_LAST) ? 8'h00 : chan + 8'h01;
          dispRefresh <= (displayModeSelect == cdt_pkg::M_STEP);
        end
        else
          advCnt <= advCnt + 11'h001;
      end
    end
  end
  // Shown data: previous bank, blank in fast modes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dispData <= '0;
      dataDispOn <= 1'b1;
    end
    else if (ce)
    begin
      dataDispOn <= isHold || (displayModeSelect == cdt_pkg::M_STEP) || !advanceToggle;
      if (advActive && !(displayModeSelect == cdt_pkg::M_STEP))
        dispData <= '0;
      else if (dispRefresh)
        dispData <= mem[{!bankSel, chan[2:0]}];
    end
  end
  // ----------------------------------------
  // Lamps and test output
  // ----------------------------------------
  // Every lamp here yields to lamp test
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      updateIndicator <= 1'b0;
      dataAvailableIndicator <= 1'b0;
      intPhaseLamp <= 1'b0;
      dispPhaseLamp <= 1'b0;
      noiseSourceIndicator <= 1'b0;
      dumpTimeIndicator <= 1'b0;
    end
    else if (ce)
    begin
      updateIndicator <= isHold || lampTest;
      dataAvailableIndicator <= dataAvail || lampTest;
      intPhaseLamp <= sigNow || lampTest;
      dispPhaseLamp <= !chan[0] || lampTest;
      noiseSourceIndicator <= noiseDrive || lampTest;
      dumpTimeIndicator <= (dumpMs >= (dumpLen >> 1)) || lampTest;
    end
  end
  // Half-rate test square wave
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      testOut <= 1'b0;
    else if (ce)
      testOut <= testSignalSelect ? !testOut : 1'b0;
  end
  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  logic apbAcc; // First access cycle
  logic mapped; // Address decodes
  logic [31:0] rdMux; // Read value
  assign apbAcc = psel && penable && !pready;
  assign apbDone = psel && penable && pready;
  assign mapped = (paddr == cdt_pkg::REG_CTRL) || (paddr == cdt_pkg::REG_STAT) ||
    (paddr == cdt_pkg::REG_DATA) || (paddr == cdt_pkg::REG_DISP) || (paddr == cdt_pkg::REG_SNAP);
  // Read decode
  always_comb
  begin
    case (paddr)
      cdt_pkg::REG_CTRL: rdMux = ctrl;
      cdt_pkg::REG_STAT: rdMux = {8'h00, chan, 4'h0, rdPtr, dumpIdx, calOn, integrate, sigNow,
        dataAvail, bankSel};
      cdt_pkg::REG_DATA: rdMux = {!rdPtr[0], mem[{!bankSel, rdPtr}]};
      cdt_pkg::REG_DISP: rdMux = {1'b0, dispData};
      cdt_pkg::REG_SNAP: rdMux = ctrlSnap;
      default: rdMux = 32'h0000_0000;
    endcase
  end
  // Answer and control writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl <= cdt_pkg::CTRL_RESET;
    end
    else if (ce)
    begin
      pready <= apbAcc;
      pslverr <= apbAcc && !mapped;
      prdata <= (apbAcc && !pwrite) ? rdMux : 32'h0000_0000;
      if (apbDone && pwrite && (paddr == cdt_pkg::REG_CTRL))
        ctrl <= pwdata;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence dumpEndSeq;
    ce && dumpEnd;
  endsequence
  sequence swapSeq;
    (bankSel != $past(bankSel)) && dataAvail && dumpIrq;
  endsequence
  blank_range_a: assert property (blankLen >= 10'h004 && blankLen <= 10'h01a && !blankLen[0])
    else $error("blanking length out of range");
  integ_after_blank_a: assert property ($rose(integrate) && $stable(blankSel) |-> phaseMs >= blankLen)
    else $error("integrating inside blanking");
  clear_blank_a: assert property (clearRegs |-> !integrate)
    else $error("phase began without blanking");
  noise_gate_a: assert property (noiseDrive |-> calOn && sigPhase)
    else $error("noise drive outside signal phase");
  bank_swap_a: assert property (dumpEndSeq |=> swapSeq)
    else $error("dump boundary did not swap and flag");
  avail_clear_a: assert property (ce && lastPop && !dumpEnd |=> !dataAvail)
    else $error("data flag stayed after last word");
  msb_alt_a: assert property (ce && apbAcc && !pwrite && paddr == cdt_pkg::REG_DATA
    |=> prdata[31] == !$past(rdPtr[0]))
    else $error("word top bit did not alternate");
  test_div_a: assert property ((ce && testSignalSelect) [*2] |-> testOut != $past(testOut))
    else $error("test output not half clock");
  cal_wrap_a: assert property (dumpEndSeq ##0
    (dumpIdx == (calTenth ? cdt_pkg::CAL_LAST_TENTH : cdt_pkg::CAL_LAST_OTHER)) |=> calOn)
    else $error("calibration schedule did not wrap");
endmodule : cdt_timing
`default_nettype wire

// file: design/cdt_pkg.sv
// Constants, types and helpers of the dump timing block
package cdt_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock
  localparam int MS_NS = 1000000; // One millisecond
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS; // Cycles per ms
  localparam logic [13:0] DUMP_SHORT_MS = 14'h03e8; // 1 s dump
  localparam logic [13:0] DUMP_LONG_MS = 14'h2710; // 10 s dump
  localparam logic [9:0] BLANK_MIN_MS = 10'h004; // Shortest blanking
  localparam logic [9:0] BLANK_STEP_MS = 10'h002; // Blanking step
  localparam logic [3:0] BLANK_SEL_MAX = 4'hb; // Step count to 26 ms
  localparam logic [9:0] H500_MS = 10'h1f4; // Half of 1 Hz
  localparam logic [9:0] H100_MS = 10'h064; // Half of 5 Hz
  localparam logic [9:0] H50_MS = 10'h032; // Half of 10 Hz
  localparam logic [9:0] H900_MS = 10'h384; // 1 Hz signal at 90 %
  localparam logic [9:0] H150_MS = 10'h096; // 5 Hz signal at 75 %
  localparam logic [3:0] CAL_LAST_OTHER = 4'h1; // Every other dump
  localparam logic [3:0] CAL_LAST_TENTH = 4'h9; // Every tenth dump
  localparam logic [10:0] ADV_SLOW_MS = 11'h4e2; // About 0.8 Hz
  localparam logic [10:0] ADV_KNOB_MS = 11'h040; // Rate knob step
  localparam logic [10:0] ADV10_MS = 11'h064; // 10 channels/s
  localparam logic [10:0] ADV50_MS = 11'h014; // 50 channels/s
  localparam logic [10:0] ADV250_MS = 11'h004; // 250 channels/s
  localparam logic [7:0] CHAN_LAST = 8'hbf; // Highest channel
  // ----------------------------------------
  // Registers and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // Control
  localparam logic [7:0] REG_STAT = 8'h04; // Status
  localparam logic [7:0] REG_DATA = 8'h08; // Dump word pop
  localparam logic [7:0] REG_DISP = 8'h0c; // Displayed data
  localparam logic [7:0] REG_SNAP = 8'h10; // Settings sent with dump
  localparam int F_RATE = 0; // Rate and duty, 3 bits
  localparam int F_BLANK = 3; // Blanking step, 4 bits
  localparam int F_DUMP = 7; // 1: ten second dump
  localparam int F_CAL = 8; // 1: calibrate every tenth dump
  localparam int F_LTEST = 9; // Lamp test
  localparam int F_TEST = 10; // Test signal select
  localparam int F_MODE = 11; // Display mode select, 3 bits
  localparam int F_ADV = 14; // Advance toggle
  localparam int F_KNOB = 15; // Advance rate knob, 4 bits
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080; // 1 Hz, 10 s
  localparam int MEM_DEPTH = 8; // Words per bank
  localparam int WORD_W = 31; // Dump word width below the flag
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {R1_50, R5_50, R10_50, R1_90, R5_75} cdt_rate_e;
  typedef enum logic [2:0] {M_HOLD, M_STEP, M_ADV10, M_ADV50, M_ADV250} cdt_mode_e;
  typedef enum logic [1:0] {PH_BSIG = 2'b00, PH_ISIG = 2'b01, PH_BREF = 2'b11,
    PH_IREF = 2'b10} cdt_phase_e;
  // Length of one half of the switching cycle
  function automatic logic [9:0] halfMs(input logic [2:0] rate, input logic isRef);
    case (cdt_rate_e'(rate))
      R5_50: halfMs = H100_MS;
      R10_50: halfMs = H50_MS;
      R1_90: halfMs = isRef ? H100_MS : H900_MS;
      R5_75: halfMs = isRef ? H50_MS : H150_MS;
      default: halfMs = H500_MS;
    endcase
  endfunction : halfMs
  // Blanking length from its step count, clamped at the top
  function automatic logic [9:0] blankMs(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > BLANK_SEL_MAX) ? BLANK_SEL_MAX : sel;
    blankMs = 10'(BLANK_MIN_MS + BLANK_STEP_MS * 10'(s));
  endfunction : blankMs
  // Channel advance period for a display mode
  function automatic logic [10:0] advMs(input logic [2:0] mode, input logic [3:0] knob);
    case (cdt_mode_e'(mode))
      M_ADV10: advMs = ADV10_MS;
      M_ADV50: advMs = ADV50_MS;
      M_ADV250: advMs = ADV250_MS;
      default: advMs = 11'(ADV_SLOW_MS - ADV_KNOB_MS * 11'(knob));
    endcase
  endfunction : advMs
endpackage : cdt_pkg

// file: design/cdt_tick_if.sv
// Millisecond tick carrier between the tick source and its user
`timescale 1ns/1ps
`default_nettype none
interface cdt_tick_if;
  logic tick; // One-cycle pulse each millisecond
  modport src (output tick);
  modport snk (input tick);
endinterface : cdt_tick_if
`default_nettype wire

// file: design/cdt_ms_tick.sv
// Millisecond tick divider from the system clock
`timescale 1ns/1ps
`default_nettype none
module cdt_ms_tick #(
  parameter int CYC = cdt_pkg::MS_CYCLES // Cycles per tick
)
(
  // Clock, reset and freeze
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Tick out
  cdt_tick_if.src t
);
  logic [31:0] cnt; // Cycles into this millisecond
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Count to the period and pulse once
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt <= 32'h0000_0000;
      t.tick <= 1'b0;
    end
    else if (ce)
    begin
      t.tick <= (cnt == 32'(CYC - 1));
      cnt <= (cnt == 32'(CYC - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
    end
  end
endmodule : cdt_ms_tick
`default_nettype wire

// file: sim/cdt_host.sv
// Computer model: APB master that unloads the finished bank
`timescale 1ns/1ps
`default_nettype none
module cdt_host
(
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdWord; // Last read data
  logic rdErr; // Last error flag
  logic [31:0] words [8]; // Unloaded dump words
  logic [31:0] acc [2]; // Sums kept per dump parity
  logic odd = 1'b0; // Parity of the next dump
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    acc[0] = 32'h0;
    acc[1] = 32'h0;
  end
  // One transfer, held until pready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdWord = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Read a whole bank, promptly or late
  task automatic unload(input int waitCyc);
    repeat (waitCyc) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      xfer(cdt_pkg::REG_DATA, 1'b0, 32'h0);
      words[i] = rdWord;
      acc[odd] = acc[odd] + {1'b0, rdWord[30:0]};
    end
    odd = ~odd;
  endtask : unload
endmodule : cdt_host
`default_nettype wire

// file: sim/correlator_dump_timing_tb.sv
// Bench for the dump timing block
`timescale 1ns/1ps
`default_nettype none
module correlator_dump_timing_tb;
  localparam int MSC = 2; // Short millisecond
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Clock enable
  logic corrWe = 1'b0;
  logic [2:0] corrAddr = 3'h0;
  logic [cdt_pkg::WORD_W-1:0] corrData = '0;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic integrate, clearRegs, sigPhase, bankSel, dumpIrq, noiseDrive, dataDispOn, testOut;
  wire logic [5:0] lamps; // Panel lamps, one port per bit
  logic prevBank; // Bank before the dump
  logic tOld; // Earlier test output
  int errorCnt = 0;
  int checkCount = 0;
  // ----------------------------------------
  // Parts
  // ----------------------------------------
  cdt_timing #(.MS_CYCLES(MSC)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .corrWe(corrWe), .corrAddr(corrAddr),
    .corrData(corrData), .integrate(integrate), .clearRegs(clearRegs), .sigPhase(sigPhase),
    .bankSel(bankSel), .dumpIrq(dumpIrq), .updateIndicator(lamps[0]),
    .dataAvailableIndicator(lamps[1]), .intPhaseLamp(lamps[2]), .dispPhaseLamp(lamps[3]),
    .noiseSourceIndicator(lamps[4]), .dumpTimeIndicator(lamps[5]), .noiseDrive(noiseDrive),
    .dataDispOn(dataDispOn), .testOut(testOut));
  cdt_host u_host (.clk_sys(clk_sys), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Wait n edges, then let them settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset state, bad address, short dump setup
  task automatic t_reset();
    chk("sigPhase", 32'h1, sigPhase);
    u_host.xfer(cdt_pkg::REG_CTRL, 1'b0, 32'h0);
    chk("ctrl", cdt_pkg::CTRL_RESET, u_host.rdWord);
    u_host.xfer(8'h20, 1'b0, 32'h0);
    chk("slverr", 32'h1, u_host.rdErr);
    chk("badData", 32'h0, u_host.rdWord);
    u_host.xfer(cdt_pkg::REG_CTRL, 1'b1, 32'h5b);
  endtask : t_reset
  // Fill bank, cross a dump, time phases, unload
  task automatic t_dump();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      corrWe <= 1'b1;
      corrAddr <= 3'(i);
      corrData <= 31'(i * 3 + 5);
    end
    @(posedge clk_sys);
    corrWe <= 1'b0;
    cyc(1);
    chk("calOn", 32'h1, noiseDrive);
    prevBank = bankSel;
    do cyc(1); while (dumpIrq !== 1'b1);
    chk("bank", {31'h0, ~prevBank}, bankSel);
    chk("clear", 32'h1, clearRegs);
    cyc(1);
    chk("irqPulse", 32'h0, dumpIrq);
    chk("dataLamp", 32'h1, lamps[1]);
    chk("dumpLampOff", 32'h0, lamps[5]);
    chk("dispLamp", 32'h1, lamps[3]);
    cyc(45);
    chk("blank", 32'h0, integrate);
    chk("calOff", 32'h0, noiseDrive);
    cyc(10);
    chk("integ", 32'h1, integrate);
    cyc(964);
    chk("dumpLampOn", 32'h1, lamps[5]);
    cyc(770);
    chk("sigLong", 32'h1, sigPhase);
    chk("intLampOn", 32'h1, lamps[2]);
    cyc(25);
    chk("refNow", 32'h0, sigPhase);
    chk("intLampOff", 32'h0, lamps[2]);
    cyc(20);
    chk("refBlank", 32'h0, integrate);
    u_host.unload(0);
    for (int i = 0; i < 8; i++)
      chk("word", {~i[0], 31'(i * 3 + 5)}, u_host.words[i]);
    cyc(2);
    chk("dataLampOff", 32'h0, lamps[1]);
    u_host.xfer(cdt_pkg::REG_DISP, 1'b0, 32'h0);
    chk("disp", 32'h5, u_host.rdWord);
    u_host.xfer(cdt_pkg::REG_SNAP, 1'b0, 32'h0);
    chk("snap", 32'h5b, u_host.rdWord);
    do cyc(1); while (dumpIrq !== 1'b1);
    cyc(1);
    chk("calBack", 32'h1, noiseDrive);
  endtask : t_dump
  // Lamp test, test signal, fast mode
  task automatic t_panel();
    u_host.xfer(cdt_pkg::REG_CTRL, 1'b1, 32'h565b);
    cyc(3);
    chk("lamps", 32'h3f, lamps);
    chk("dispOff", 32'h0, dataDispOn);
    tOld = testOut;
    cyc(1);
    chk("testOut", {31'h0, ~tOld}, testOut);
    @(posedge clk_sys);
    ce <= 1'b0;
    cyc(1);
    tOld = testOut;
    cyc(3);
    chk("freeze", {31'h0, tOld}, testOut);
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(250);
    u_host.xfer(cdt_pkg::REG_STAT, 1'b0, 32'h0);
    chk("chan", 32'h1, u_host.rdWord[23:16]);
  endtask : t_panel
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_dump();
    t_panel();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #100000;
    errorCnt++;
    end_of_test();
  end
endmodule : correlator_dump_timing_tb
`default_nettype wire
